/* File: shared/sdfc_pkg.sv */
// constants, field layouts and types of the sinc filter, chop and calibration block
// Summary of operation
// - third-order sinc decimator; decimation factor register sets cutoff and output word rate
// - mode bit 6 inserts the fixed 60 Hz notch; clearing it removes the notch
// - with chopping on, input polarity swaps after every filter output
// - with chopping on, each filter output is averaged with the previous one
// - mode bit 3 at 1 disables chopping; at 0 chopping stays active
// - four calibration modes are chosen by the mode select field
// - after any reset the factory offset and gain coefficients are loaded
// - a user calibration overwrites the factory coefficients
// - zero-scale result goes to offset coefficient, full-scale result to gain coefficient
// - internal calibration switches the internal zero or full-scale input onto the converter
// - calibration conversions run at the user decimation factor
// - results are offset-subtracted, then multiplied by the normalized gain coefficient
// - end of calibration is shown by the done flag; software polls it
// - missing reference during calibration conversions stops it and leaves coefficients unwritten; the gain division phase ignores it
// - mode select 100B starts internal zero-scale, 101B internal full-scale calibration
// - missing reference inhibiting a calibration sets the calibration error bit
// - decimation factor clamps to 13 with chopping, to 3 without; maximum 255
// - mode select 110B starts system zero-scale, 111B system full-scale calibration
package sdfc_pkg;
	localparam logic [7:0]  ADDR_MODE       = 8'h00;
	localparam logic [7:0]  ADDR_STATUS     = 8'h04;
	localparam logic [7:0]  ADDR_DECIM      = 8'h08;
	localparam logic [7:0]  ADDR_RESULT     = 8'h0C;
	localparam logic [7:0]  ADDR_OFFSET     = 8'h10;
	localparam logic [7:0]  ADDR_GAIN       = 8'h14;

	localparam int          MODE_W          = 7;
	localparam int          STAT_DONE_BIT   = 0;
	localparam int          STAT_REFMIS_BIT = 1;
	localparam int          STAT_CALERR_BIT = 2;
	localparam int          STAT_BUSY_BIT   = 3;

	localparam logic [7:0]  DECIM_RESET     = 8'h45;
	localparam logic [7:0]  DECIM_MIN_CHOP  = 8'h0D;
	localparam logic [7:0]  DECIM_MIN_PLAIN = 8'h03;

	localparam int          MOD_RATE_HZ     = 32768;
	localparam int          NOTCH_HZ        = 60;
	localparam int          NOTCH_LEN       = MOD_RATE_HZ / NOTCH_HZ;
	localparam int          RAW_W           = 34;

	localparam logic [2:0]  CAL_OUTPUTS     = 3'h5;
	localparam int          GAIN_FRAC       = 16;
	localparam logic [23:0] FULL_CODE       = 24'hFFFFFF;
	localparam logic [5:0]  DIV_STEPS       = 6'h28;
	localparam logic [31:0] FACTORY_OFFSET  = 32'h00000000;
	localparam logic [31:0] FACTORY_GAIN    = 32'h00010000;

	typedef enum logic [2:0]
	{
		MSEL_IDLE     = 3'b000,
		MSEL_CONT     = 3'b011,
		MSEL_INT_ZERO = 3'b100,
		MSEL_INT_FULL = 3'b101,
		MSEL_SYS_ZERO = 3'b110,
		MSEL_SYS_FULL = 3'b111
	} sdfc_msel_t;

	typedef enum logic [1:0]
	{
		CAL_IDLE = 2'b00,
		CAL_RUN  = 2'b01,
		CAL_DIV  = 2'b10
	} sdfc_cal_t;

	typedef struct packed
	{
		logic       notch_sixty_enable;
		logic       spare;
		logic       conv_en;
		logic       chop_off;
		logic [2:0] mode_select_field;
	} sdfc_mode_t;

	typedef struct packed
	{
		logic             valid;
		logic [RAW_W-1:0] data;
	} sdfc_word_t;
endpackage : sdfc_pkg

/* File: design/sdfc_sinc3.sv */
// sinc3 decimator with optional fixed boxcar notch on the modulator stream
module sdfc_sinc3 #(
	parameter int NOTCH_LEN = sdfc_pkg::NOTCH_LEN
) (
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               sample,
	input  wire logic               bit_in,
	input  wire logic [7:0]         decim,
	input  wire logic               notch_en,
	output sdfc_pkg::sdfc_word_t    word
);
	localparam int BOX_W = $clog2(NOTCH_LEN + 1);
	localparam int PTR_W = $clog2(NOTCH_LEN);
	localparam int RW    = sdfc_pkg::RAW_W;

	logic             hist_reg [NOTCH_LEN];
	logic [PTR_W-1:0] ptr_reg;
	logic [BOX_W-1:0] box_reg;
	logic [RW-1:0]    int1_reg, int2_reg, int3_reg;
	logic [RW-1:0]    z1_reg, z2_reg, z3_reg;
	logic [7:0]       dcnt_reg;

	wire logic             oldest   = hist_reg[ptr_reg];
	wire logic [BOX_W-1:0] box_next = box_reg + BOX_W'(bit_in) - BOX_W'(oldest);
	wire logic             ptr_wrap = (ptr_reg == PTR_W'(NOTCH_LEN - 1));
	// both paths carry the same dc gain so the notch does not rescale results
	wire logic [BOX_W-1:0] x_in     = notch_en ? box_reg : (bit_in ? BOX_W'(NOTCH_LEN) : '0);
	wire logic             dec_last = (dcnt_reg >= decim - 8'h01);
	wire logic [RW-1:0]    c1       = int3_reg - z1_reg;
	wire logic [RW-1:0]    c2       = c1 - z2_reg;
	wire logic [RW-1:0]    c3       = c2 - z3_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NOTCH_LEN; i++)
				hist_reg[i] <= 1'b0;
			ptr_reg <= '0;
			box_reg <= '0;
		end
		else if (sample)
		begin
			hist_reg[ptr_reg] <= bit_in;
			ptr_reg           <= ptr_wrap ? '0 : ptr_reg + PTR_W'(1);
			box_reg           <= box_next;
		end
	end

	// integrators at modulator rate, combs at the decimated rate
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			int1_reg <= '0;
			int2_reg <= '0;
			int3_reg <= '0;
			z1_reg   <= '0;
			z2_reg   <= '0;
			z3_reg   <= '0;
			dcnt_reg <= 8'h00;
			word     <= '0;
		end
		else
		begin
			word.valid <= 1'b0;
			if (sample)
			begin
				int1_reg <= int1_reg + RW'(x_in);
				int2_reg <= int2_reg + int1_reg;
				int3_reg <= int3_reg + int2_reg;
				dcnt_reg <= dec_last ? 8'h00 : dcnt_reg + 8'h01;
				if (dec_last)
				begin
					z1_reg     <= int3_reg;
					z2_reg     <= c1;
					z3_reg     <= c2;
					word.data  <= c3;
					word.valid <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_notch_box_range: assert property (box_reg <= BOX_W'(NOTCH_LEN))
		else $error("notch window count exceeds its length");
	a_decim_rate: assert property (word.valid |=> !word.valid [*2])
		else $error("filter words closer than decimation allows");
endmodule : sdfc_sinc3

/* File: design/sdfc_top.sv */
// converter back end: ahb registers, chop averaging, coefficient correction, calibration sequencer
module sdfc_top #(
	parameter logic [31:0] FACTORY_OFFSET = sdfc_pkg::FACTORY_OFFSET,
	parameter logic [31:0] FACTORY_GAIN   = sdfc_pkg::FACTORY_GAIN,
	parameter int          NOTCH_LEN      = sdfc_pkg::NOTCH_LEN
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        mod_strobe_pin,
	input  wire logic        mod_data_pin,
	input  wire logic        ref_missing_pin,
	output logic             chop_swap,
	output logic [1:0]       cal_input_sel,
	output logic             conv_enable
);
	localparam int RW = sdfc_pkg::RAW_W;

	function automatic logic [7:0] clamp_decim(input logic [7:0] v, input logic chop);
		logic [7:0] lo;
		lo = chop ? sdfc_pkg::DECIM_MIN_CHOP : sdfc_pkg::DECIM_MIN_PLAIN;
		clamp_decim = (v < lo) ? lo : v;
	endfunction : clamp_decim

	// pin synchronisers: stage 1 feeds stage 2 only
	logic [2:0] pin_s1_reg, pin_s2_reg;
	logic       strobe_d_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_s1_reg   <= 3'h0;
			pin_s2_reg   <= 3'h0;
			strobe_d_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg   <= {ref_missing_pin, mod_data_pin, mod_strobe_pin};
			pin_s2_reg   <= pin_s1_reg;
			strobe_d_reg <= pin_s2_reg[0];
		end
	end

	wire logic mod_sample  = pin_s2_reg[0] & ~strobe_d_reg;
	wire logic mod_bit     = pin_s2_reg[1];
	wire logic ref_missing = pin_s2_reg[2];

	sdfc_pkg::sdfc_mode_t mode_reg;
	sdfc_pkg::sdfc_cal_t  cal_state;
	sdfc_pkg::sdfc_word_t filt;
	logic [7:0]           decim_reg;
	logic                 done_reg, calerr_reg, cal_full_reg;
	logic [2:0]           cal_cnt_reg;
	logic [31:0]          result_reg, offset_reg, gain_reg;
	logic [RW-1:0]        prev_reg;
	logic [39:0]          num_reg, quo_reg;
	logic [35:0]          rem_reg, den_reg;
	logic [5:0]           div_cnt_reg;
	logic                 wr_pend_reg;
	logic [7:0]           wr_addr_reg;

	wire logic       chop_on   = ~mode_reg.chop_off;
	wire logic [7:0] eff_decim = clamp_decim(decim_reg, chop_on);
	wire logic       run_cont  = mode_reg.conv_en & (mode_reg.mode_select_field == sdfc_pkg::MSEL_CONT);

	// the filter always runs at the clamped user factor, calibration included
	sdfc_sinc3 #(
		.NOTCH_LEN (NOTCH_LEN)
	) u_sinc (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.sample   (mod_sample),
		.bit_in   (mod_bit),
		.decim    (eff_decim),
		.notch_en (mode_reg.notch_sixty_enable),
		.word     (filt)
	);

	// chop averaging and coefficient correction
	wire logic [RW:0]   pair_sum  = {1'b0, filt.data} + {1'b0, prev_reg};
	wire logic [RW-1:0] avg       = chop_on ? pair_sum[RW:1] : filt.data;
	wire logic [35:0]   diff      = 36'({2'b00, avg}) - 36'({{4{offset_reg[31]}}, offset_reg});
	wire logic [68:0]   prod      = 69'($signed(diff) * $signed({1'b0, gain_reg}));
	wire logic [31:0]   corrected = prod[sdfc_pkg::GAIN_FRAC +: 32];

	// bus decode
	wire logic       addr_ok  = hsel & htrans[1] & hready;
	wire logic       rd_req   = addr_ok & ~hwrite;
	wire logic       mapped   = (haddr[31:8] == 24'h000000);
	wire logic [7:0] ra       = haddr[7:0];
	wire logic       wr_mode  = wr_pend_reg & (wr_addr_reg == sdfc_pkg::ADDR_MODE);
	wire logic       wr_stat  = wr_pend_reg & (wr_addr_reg == sdfc_pkg::ADDR_STATUS);
	wire logic       wr_decim = wr_pend_reg & (wr_addr_reg == sdfc_pkg::ADDR_DECIM);
	wire logic       wr_off   = wr_pend_reg & (wr_addr_reg == sdfc_pkg::ADDR_OFFSET);
	wire logic       wr_gain  = wr_pend_reg & (wr_addr_reg == sdfc_pkg::ADDR_GAIN);
	wire sdfc_pkg::sdfc_mode_t mode_wval = sdfc_pkg::sdfc_mode_t'(hwdata[sdfc_pkg::MODE_W-1:0]);
	wire logic       cal_busy = (cal_state != sdfc_pkg::CAL_IDLE);

	wire logic [31:0] status_val = {28'h0000000, cal_busy, calerr_reg, ref_missing, done_reg};
	wire logic [31:0] rd_data =
		!mapped                           ? 32'h00000000 :
		(ra == sdfc_pkg::ADDR_MODE)       ? {25'h0000000, mode_reg} :
		(ra == sdfc_pkg::ADDR_STATUS)     ? status_val :
		(ra == sdfc_pkg::ADDR_DECIM)      ? {24'h000000, decim_reg} :
		(ra == sdfc_pkg::ADDR_RESULT)     ? result_reg :
		(ra == sdfc_pkg::ADDR_OFFSET)     ? offset_reg :
		(ra == sdfc_pkg::ADDR_GAIN)       ? gain_reg : 32'h00000000;

	// calibration sequencing
	wire logic cal_req    = wr_mode & mode_wval.conv_en & mode_wval.mode_select_field[2];
	wire logic sw_cancel  = wr_mode & ~cal_req;
	wire logic in_run     = (cal_state == sdfc_pkg::CAL_RUN);
	wire logic cal_abort  = in_run & ~wr_mode & ref_missing;
	wire logic cal_last   = in_run & ~wr_mode & ~ref_missing & filt.valid
		& (cal_cnt_reg == sdfc_pkg::CAL_OUTPUTS - 3'h1);
	wire logic zero_done  = cal_last & ~cal_full_reg;
	wire logic full_done  = cal_last & cal_full_reg;
	wire logic div_last   = (cal_state == sdfc_pkg::CAL_DIV) & (div_cnt_reg == sdfc_pkg::DIV_STEPS - 6'h01);
	wire logic cal_end    = cal_abort | zero_done | div_last;
	wire logic den_bad    = diff[35] | (diff == 36'h000000000);

	// restoring division for the gain coefficient
	wire logic [35:0] rem_sh   = {rem_reg[34:0], num_reg[39]};
	wire logic        div_ge   = (rem_sh >= den_reg);
	wire logic [35:0] rem_next = div_ge ? rem_sh - den_reg : rem_sh;
	wire logic [39:0] quo_next = {quo_reg[38:0], div_ge};

	wire logic result_load = run_cont & ~cal_busy & filt.valid;
	wire logic done_set    = result_load | cal_end;
	wire logic done_clr    = wr_stat & hwdata[sdfc_pkg::STAT_DONE_BIT];
	wire logic err_clr     = wr_stat & hwdata[sdfc_pkg::STAT_CALERR_BIT];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata      <= 32'h00000000;
		end
		else
		begin
			wr_pend_reg <= addr_ok & hwrite & mapped;
			wr_addr_reg <= ra;
			hrdata      <= rd_req ? rd_data : 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_reg   <= '0;
			decim_reg  <= sdfc_pkg::DECIM_RESET;
			done_reg   <= 1'b0;
			calerr_reg <= 1'b0;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= mode_wval;
			else if (cal_end)
				mode_reg.mode_select_field <= sdfc_pkg::MSEL_IDLE;
			if (wr_decim)
				decim_reg <= hwdata[7:0];
			done_reg   <= done_set | (done_reg & ~done_clr);
			calerr_reg <= cal_abort | (calerr_reg & ~err_clr);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			offset_reg <= FACTORY_OFFSET;
			gain_reg   <= FACTORY_GAIN;
			result_reg <= 32'h00000000;
			prev_reg   <= '0;
			chop_swap  <= 1'b0;
		end
		else
		begin
			if (zero_done)
				offset_reg <= 32'(diff + 36'({{4{offset_reg[31]}}, offset_reg}));
			else if (wr_off)
				offset_reg <= hwdata;
			if (div_last)
				gain_reg <= quo_next[31:0];
			else if (wr_gain)
				gain_reg <= hwdata;
			if (result_load)
				result_reg <= corrected;
			if (filt.valid)
			begin
				prev_reg  <= filt.data;
				chop_swap <= chop_swap ^ chop_on;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cal_state    <= sdfc_pkg::CAL_IDLE;
			cal_full_reg <= 1'b0;
			cal_cnt_reg  <= 3'h0;
			num_reg      <= 40'h0000000000;
			quo_reg      <= 40'h0000000000;
			rem_reg      <= 36'h000000000;
			den_reg      <= 36'h000000001;
			div_cnt_reg  <= 6'h00;
		end
		else
		begin
			case (cal_state)
				sdfc_pkg::CAL_IDLE:
				begin
					if (cal_req)
					begin
						cal_state    <= sdfc_pkg::CAL_RUN;
						cal_full_reg <= mode_wval.mode_select_field[0];
						cal_cnt_reg  <= 3'h0;
					end
				end
				sdfc_pkg::CAL_RUN:
				begin
					if (cal_req)
					begin
						cal_full_reg <= mode_wval.mode_select_field[0];
						cal_cnt_reg  <= 3'h0;
					end
					else if (sw_cancel | cal_abort)
						cal_state <= sdfc_pkg::CAL_IDLE;
					else if (zero_done)
						cal_state <= sdfc_pkg::CAL_IDLE;
					else if (full_done)
					begin
						cal_state   <= sdfc_pkg::CAL_DIV;
						num_reg     <= {sdfc_pkg::FULL_CODE, 16'h0000};
						quo_reg     <= 40'h0000000000;
						rem_reg     <= 36'h000000000;
						den_reg     <= den_bad ? 36'h000000001 : diff;
						div_cnt_reg <= 6'h00;
					end
					else if (filt.valid)
						cal_cnt_reg <= cal_cnt_reg + 3'h1;
				end
				sdfc_pkg::CAL_DIV:
				begin
					num_reg     <= {num_reg[38:0], 1'b0};
					rem_reg     <= rem_next;
					quo_reg     <= quo_next;
					div_cnt_reg <= div_cnt_reg + 6'h01;
					if (div_last)
						cal_state <= sdfc_pkg::CAL_IDLE;
				end
				default:
					cal_state <= sdfc_pkg::CAL_IDLE;
			endcase
		end
	end

	// internal references only for the internal calibration modes
	wire logic int_cal = in_run & ~mode_reg.mode_select_field[1];
	assign cal_input_sel = int_cal ? (cal_full_reg ? 2'b10 : 2'b01) : 2'b00;
	assign conv_enable   = mode_reg.conv_en;
	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_decim_clamp: assert property (eff_decim >= (chop_on ? 8'h0D : 8'h03))
		else $error("effective decimation factor below minimum");
	a_chop_toggle: assert property (filt.valid && chop_on |=> chop_swap != $past(chop_swap))
		else $error("chop polarity did not swap after filter output");
	a_chop_hold: assert property (!chop_on |=> $stable(chop_swap))
		else $error("chop polarity moved with chopping disabled");
	a_avg_result: assert property (result_load && chop_on |=> result_reg == $past(corrected))
		else $error("averaged result not written");
	a_ref_no_write: assert property (cal_abort |=> $stable(offset_reg) && $stable(gain_reg))
		else $error("coefficient written despite missing reference");
	a_ref_err_done: assert property (cal_abort |=> calerr_reg && done_reg && !cal_busy)
		else $error("abort did not flag error and done");
	a_cal_start: assert property (cal_req && cal_state != sdfc_pkg::CAL_DIV |=> in_run && mode_reg.mode_select_field[2])
		else $error("calibration did not start");
	a_int_input: assert property (in_run && mode_reg.mode_select_field == sdfc_pkg::MSEL_INT_FULL
		|-> cal_input_sel == 2'b10)
		else $error("internal full-scale input not selected");
	a_sys_input: assert property (in_run && mode_reg.mode_select_field[1] |-> cal_input_sel == 2'b00)
		else $error("system calibration drove internal input");
	a_zero_store: assert property (zero_done |=> offset_reg == 32'($past(avg)) && done_reg)
		else $error("zero-scale result not stored in offset");
	a_div_bound: assert property ($rose(cal_state == sdfc_pkg::CAL_DIV) |-> ##[39:40] !cal_busy)
		else $error("gain division did not finish in 40 cycles");

	c_zero_cal: cover property (zero_done);
	c_full_cal: cover property (div_last);
	c_ref_abort: cover property (cal_abort);
	c_notch_result: cover property (result_load && mode_reg.notch_sixty_enable);
endmodule : sdfc_top

/* File: tb/sdfc_mod_model.sv */
// modulator stand-in: strobe every four cycles, bit follows the selected input
module sdfc_mod_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [1:0] cal_input_sel,
	input  wire logic       pin_level,
	output logic            mod_strobe_pin,
	output logic            mod_data_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_reg;
	wire logic  level_sel = (cal_input_sel == 2'h1) ? 1'b0 : (cal_input_sel == 2'h2) ? 1'b1 : pin_level;
	assign mod_strobe_pin = phase_reg[1];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_reg + 2'h1;
	end
	// bit changes while strobe is low, so it is stable at the rising strobe
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			mod_data_pin <= 1'b0;
		else if (phase_reg == 2'h0)
			mod_data_pin <= level_sel;
	end
endmodule : sdfc_mod_model

/* File: tb/sdfc_top_tb.sv */
// self-checking bench: registers, conversions, calibration modes, reference loss
module sdfc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NL = 4;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, cal_input_sel;
	logic [2:0]  hsize;
	logic        pin_level, ref_missing_pin, strobe, mdata, chop_swap, conv_enable;
	int          errors, compares;

	sdfc_top #(.NOTCH_LEN(NL)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mod_strobe_pin(strobe),
		.mod_data_pin(mdata), .ref_missing_pin(ref_missing_pin), .chop_swap(chop_swap),
		.cal_input_sel(cal_input_sel), .conv_enable(conv_enable));
	sdfc_mod_model MODEL (.hclk(hclk), .hresetn(hresetn), .cal_input_sel(cal_input_sel),
		.pin_level(pin_level), .mod_strobe_pin(strobe), .mod_data_pin(mdata));

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, addr};
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0, "response");
	endtask : bus

	task automatic wr(input logic [7:0] addr, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, addr, d, x);
	endtask : wr

	task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
		logic [31:0] x;
		bus(1'b0, addr, 32'h0, x);
		check(x, exp, what);
	endtask : rd_chk

	// polls until done, then clears done and error
	task automatic wait_done(output logic [31:0] st);
		int n;
		n = 0;
		st = 32'h0;
		while (st[sdfc_pkg::STAT_DONE_BIT] !== 1'b1 && n < 4000)
		begin
			bus(1'b0, sdfc_pkg::ADDR_STATUS, 32'h0, st);
			n++;
		end
		check({31'h0, st[sdfc_pkg::STAT_DONE_BIT]}, 32'h1, "done flag");
		wr(sdfc_pkg::ADDR_STATUS, 32'h00000005);
	endtask : wait_done

	function automatic logic [31:0] exp_res(input int d, input logic [31:0] off, input logic [31:0] g);
		logic [63:0] p;
		p = (64'(NL * d * d * d) - {32'h0, off}) * {32'h0, g};
		return p[47:16];
	endfunction : exp_res

	function automatic logic [31:0] gain_of(input int d);
		logic [63:0] q;
		q = 64'hFFFFFF0000 / 64'(NL * d * d * d);
		return q[31:0];
	endfunction : gain_of

	task automatic t_reset;
		logic [31:0] r0;
		rd_chk(sdfc_pkg::ADDR_OFFSET, sdfc_pkg::FACTORY_OFFSET, "factory offset");
		rd_chk(sdfc_pkg::ADDR_GAIN, sdfc_pkg::FACTORY_GAIN, "factory gain");
		rd_chk(sdfc_pkg::ADDR_DECIM, {24'h000000, sdfc_pkg::DECIM_RESET}, "decim reset");
		rd_chk(sdfc_pkg::ADDR_MODE, 32'h0, "mode reset");
		check({30'h0, chop_swap, conv_enable}, 32'h0, "outputs at reset");
		wr(8'h20, 32'hFFFFFFFF);
		rd_chk(8'h20, 32'h0, "unmapped");
		bus(1'b0, sdfc_pkg::ADDR_RESULT, 32'h0, r0);
		wr(sdfc_pkg::ADDR_RESULT, ~r0);
		rd_chk(sdfc_pkg::ADDR_RESULT, r0, "result read only");
	endtask : t_reset

	task automatic t_convert(input int decim, input logic chop_off, input logic notch, input int d);
		logic [31:0] st;
		logic        s_a, s_b;
		pin_level <= 1'b1;
		wr(sdfc_pkg::ADDR_OFFSET, 32'h00000008);
		wr(sdfc_pkg::ADDR_GAIN, 32'h00020000);
		wr(sdfc_pkg::ADDR_DECIM, 32'(decim));
		wr(sdfc_pkg::ADDR_MODE, {25'h0, notch, 1'b0, 1'b1, chop_off, 3'b011});
		repeat (5)
			wait_done(st);
		s_a = chop_swap;
		wait_done(st);
		s_b = chop_swap;
		check({31'h0, s_a ^ s_b}, {31'h0, ~chop_off}, "polarity swap");
		check({31'h0, conv_enable}, 32'h1, "converter enable");
		rd_chk(sdfc_pkg::ADDR_RESULT, exp_res(d, 32'h8, 32'h20000), "result");
		wr(sdfc_pkg::ADDR_MODE, 32'h0);
	endtask : t_convert

	task automatic t_cal(input logic [2:0] msel, input logic pin, input logic full, input logic [1:0] sel);
		logic [31:0] st;
		pin_level <= pin;
		wr(sdfc_pkg::ADDR_DECIM, 32'h000000FF);
		if (full)
			wr(sdfc_pkg::ADDR_GAIN, 32'h00012345);
		else
			wr(sdfc_pkg::ADDR_OFFSET, 32'h00000005);
		wr(sdfc_pkg::ADDR_MODE, {25'h0, 4'h3, msel});
		@(negedge hclk);
		check({30'h0, cal_input_sel}, {30'h0, sel}, "calibration input");
		@(posedge hclk);
		wait_done(st);
		check({31'h0, st[sdfc_pkg::STAT_CALERR_BIT]}, 32'h0, "no cal error");
		if (full)
			rd_chk(sdfc_pkg::ADDR_GAIN, gain_of(255), "gain coefficient");
		else
			rd_chk(sdfc_pkg::ADDR_OFFSET, 32'h0, "offset coefficient");
		rd_chk(sdfc_pkg::ADDR_MODE, 32'h00000018, "mode after cal");
	endtask : t_cal

	task automatic t_refloss;
		logic [31:0] st;
		wr(sdfc_pkg::ADDR_GAIN, 32'h00030000);
		wr(sdfc_pkg::ADDR_MODE, {25'h0, 4'h3, 3'b101});
		repeat (20)
			@(posedge hclk);
		ref_missing_pin <= 1'b1;
		wait_done(st);
		check({29'h0, st[3:1]}, 32'h3, "cal error and ref flag");
		rd_chk(sdfc_pkg::ADDR_GAIN, 32'h00030000, "gain kept");
		rd_chk(sdfc_pkg::ADDR_MODE, 32'h00000018, "cal stopped");
		ref_missing_pin <= 1'b0;
		repeat (6)
			@(posedge hclk);
		rd_chk(sdfc_pkg::ADDR_STATUS, 32'h0, "status cleared");
	endtask : t_refloss

	// reset in mid-run must bring back the factory coefficients
	task automatic t_rst_again;
		wr(sdfc_pkg::ADDR_OFFSET, 32'h00000033);
		hresetn <= 1'b0;
		repeat (2)
			@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(sdfc_pkg::ADDR_OFFSET, sdfc_pkg::FACTORY_OFFSET, "offset reload");
		rd_chk(sdfc_pkg::ADDR_GAIN, sdfc_pkg::FACTORY_GAIN, "gain reload");
		rd_chk(sdfc_pkg::ADDR_MODE, 32'h0, "mode after second reset");
	endtask : t_rst_again

	task automatic wrap_up;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	initial
	begin
		hclk = 1'b0;
		forever
			#2 hclk = ~hclk;
	end

	initial
	begin
		repeat (60000)
			@(posedge hclk);
		errors++;
		$display("ERROR %0t watchdog expired", $time);
		wrap_up();
	end

	initial
	begin
		errors = 0;
		compares = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pin_level = 1'b0;
		ref_missing_pin = 1'b0;
		repeat (2)
			@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_convert(5, 1'b0, 1'b0, 13);
		t_convert(2, 1'b1, 1'b0, 3);
		t_convert(20, 1'b1, 1'b0, 20);
		t_convert(68, 1'b0, 1'b1, 68);
		t_cal(3'b100, 1'b1, 1'b0, 2'h1);
		t_cal(3'b101, 1'b0, 1'b1, 2'h2);
		t_cal(3'b110, 1'b0, 1'b0, 2'h0);
		t_cal(3'b111, 1'b1, 1'b1, 2'h0);
		t_refloss();
		t_rst_again();
		wrap_up();
	end
endmodule : sdfc_top_tb
